// File: src/overflow_guard_timer_regs.svh
// constants for the overflow guard timer: timeout encodings, clock figures
// assumes mclk at 250 MHz; the low_freq_oscillator tick arrives as a pin level
// Behaviour
// R01 - counter advances only on low-frequency oscillator ticks, never on mclk alone
// R02 - counter overflow raises a core reset request like a system reset
// R03 - software must restart the count before overflow, every time
// R04 - after any reset the timer runs enabled with the longest timeout
// R05 - software may disable the timer unless it has been locked
// R06 - once locked, disable and timeout changes are ignored until reset
// R07 - watchdog reset never drives the external reset pin
// R08 - oscillator nominal rate is 80 kHz
// R09 - selectable timeouts, longest by default, applied at next restart
`ifndef OVERFLOW_GUARD_TIMER_REGS_SVH
`define OVERFLOW_GUARD_TIMER_REGS_SVH
`define OGT_LFO_KHZ 80
`define OGT_MCLK_KHZ 250000
`define OGT_SEL_W 3
`define OGT_SEL_MAX 3'h7
`define OGT_CNT_W 24
`define OGT_BASE_SHIFT 10
`define OGT_RST_HOLD_NS 1000
`define OGT_RST_HOLD_CYC ((`OGT_RST_HOLD_NS * (`OGT_MCLK_KHZ / 1000) + 999) / 1000)
`endif

// File: src/overflow_guard_timer_pkg.sv
// types for the overflow guard timer
// assumes the constants header is included where numbers are needed
package overflow_guard_timer_pkg;
    typedef enum logic [1:0] {RUNNING, STOPPED, FIRING} guardState_t;
endpackage

// File: src/edge_tick_sync.sv
// two-flop synchroniser plus rising-edge pulse for the oscillator level
// assumes the input is asynchronous to mclk and much slower than it
`timescale 1ns/1ps
module edge_tick_sync (
    input wire logic mclk,
    input wire logic reset,
    input wire logic levelIn,
    output logic tick
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
        logic tick;
    } syncState_t;
    syncState_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        s_d.meta = levelIn;
        s_d.sync = s_q.meta;
        s_d.last = s_q.sync;
        s_d.tick = s_q.sync & ~s_q.last;
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign tick = s_q.tick;
endmodule

// File: src/overflow_guard_timer.sv
// overflow guard timer: watchdog counting low_freq_oscillator edges
// assumes reset is the system reset and that coreResetReq is fed back into it
`timescale 1ns/1ps
`include "overflow_guard_timer_regs.svh"
module overflow_guard_timer
    import overflow_guard_timer_pkg::*;
#(
    parameter int CNT_W = `OGT_CNT_W
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic lowFreqOsc,
    input wire logic restartReq,
    input wire logic disableReq,
    input wire logic lockReq,
    input wire logic selWrite,
    input wire logic [`OGT_SEL_W-1:0] selIn,
    output logic coreResetReq,
    output logic enabled,
    output logic locked,
    output logic [`OGT_SEL_W-1:0] selActive,
    output logic resetPinDrive
);
    typedef struct packed {
        guardState_t st;
        logic [CNT_W-1:0] count;
        logic [`OGT_SEL_W-1:0] selPend;
        logic [`OGT_SEL_W-1:0] selAct;
        logic lock;
        logic en;
        logic pinDrv;
        logic fire;
        logic [7:0] hold;
    } guard_t;
    guard_t g_q, g_d;
    logic lfoTick;

    // limit for a selection: doubles with each step
    function automatic logic [CNT_W-1:0] limitOf(input logic [`OGT_SEL_W-1:0] sel);
        logic [CNT_W-1:0] one;
        one = {{(CNT_W-1){1'b0}}, 1'b1};
        limitOf = (one << (`OGT_BASE_SHIFT + 32'(sel))) - one;
    endfunction

    edge_tick_sync u_sync (
        .mclk(mclk),
        .reset(reset),
        .levelIn(lowFreqOsc),
        .tick(lfoTick)
    );

    always_comb begin
        g_d = g_q;
        g_d.fire = 1'b0;
        if (lockReq) begin
            g_d.lock = 1'b1; // see R06
        end
        // changes only take when unlocked; lock is sticky until reset
        if (selWrite && !g_q.lock) begin
            g_d.selPend = selIn; // see R06 see R09
        end
        case (g_q.st)
            RUNNING: begin
                if (disableReq && !g_q.lock && !lockReq) begin
                    g_d.st = STOPPED; // see R05
                    g_d.en = 1'b0;
                end else if (restartReq) begin
                    g_d.count = '0; // see R03
                    g_d.selAct = g_d.selPend; // see R09
                end else if (lfoTick) begin
                    // advance only on oscillator edges for source independence
                    if (g_q.count >= limitOf(g_q.selAct)) begin
                        g_d.st = FIRING; // see R02
                        // raised on entry so a late disable never meets a silent firing state
                        g_d.fire = 1'b1;
                        g_d.hold = 8'(`OGT_RST_HOLD_CYC);
                    end else begin
                        g_d.count = g_q.count + 1'b1; // see R01 see R08
                    end
                end
            end
            STOPPED: begin
                if (restartReq) begin
                    g_d.st = RUNNING;
                    g_d.en = 1'b1;
                    g_d.count = '0;
                    g_d.selAct = g_d.selPend;
                end
            end
            FIRING: begin
                // held long enough for the system reset to catch it
                g_d.fire = 1'b1; // see R02
                if (g_q.hold != 8'h00) begin
                    g_d.hold = g_q.hold - 8'h01;
                end
            end
            default: begin
                g_d.st = RUNNING;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            g_q.st <= RUNNING; // see R04
            g_q.count <= '0;
            g_q.selPend <= `OGT_SEL_MAX; // see R04 see R09
            g_q.selAct <= `OGT_SEL_MAX;
            g_q.lock <= 1'b0;
            g_q.en <= 1'b1; // see R04
            g_q.pinDrv <= 1'b0; // see R07
            g_q.fire <= 1'b0;
            g_q.hold <= 8'h00;
        end else begin
            g_q <= g_d;
        end
    end

    assign coreResetReq = g_q.fire;
    assign enabled = g_q.en;
    assign locked = g_q.lock;
    assign selActive = g_q.selAct;
    // the pin is never driven by this block
    assign resetPinDrive = g_q.pinDrv; // see R07
endmodule

// File: verif/overflow_guard_timer_monitor.sv
// port checker for the overflow guard timer
// assumes a bind from the bench top
`timescale 1ns/1ps
module overflow_guard_timer_monitor (
    input wire logic mclk,
    input wire logic reset,
    input wire logic restartReq,
    input wire logic disableReq,
    input wire logic lockReq,
    input wire logic coreResetReq,
    input wire logic enabled,
    input wire logic locked,
    input wire logic [2:0] selActive,
    input wire logic resetPinDrive
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    a_reset_state: assert property (disable iff (1'b0)
        reset ##1 reset |-> enabled && !locked && selActive == 3'h7) else $error("reset state");
    a_pin_quiet: assert property (!resetPinDrive) else $error("pin driven");
    a_lock_sticky: assert property (locked |=> locked) else $error("lock lost");
    a_lock_keeps_on: assert property (locked && enabled |=> enabled) else $error("locked stop");
    a_sel_at_restart: assert property (!restartReq |=> $stable(selActive)) else $error("sel moved");
    a_disable_stops: assert property (disableReq && !lockReq && !locked && !coreResetReq
        |=> !enabled) else $error("no stop");
    a_fire_sticks: assert property (coreResetReq |=> coreResetReq) else $error("fire dropped");
    a_stopped_quiet: assert property (!enabled |-> !coreResetReq) else $error("fired stopped");
    c_fire: cover property ($rose(coreResetReq));
    c_stop: cover property ($fell(enabled));
    c_lock: cover property ($rose(locked));
endmodule

// File: verif/overflow_guard_timer_tb.sv
// bench for the overflow guard timer: reset, disable, timeout, lock
// assumes design and checker compiled first
`timescale 1ns/1ps
module overflow_guard_timer_tb;
    logic mclk = 0, reset = 1, lowFreqOsc = 0, restartReq = 0, disableReq = 0, lockReq = 0, selWrite = 0;
    logic [2:0] selIn = 3'h0;
    logic coreResetReq, enabled, locked, resetPinDrive;
    logic [2:0] selActive;
    int errCount = 0, totalChecks = 0;
    always #2 mclk = ~mclk;
    // fast oscillator stand-in keeps timeouts short
    always #16 lowFreqOsc = ~lowFreqOsc;
    overflow_guard_timer dut_u (
        .mclk(mclk),
        .reset(reset),
        .lowFreqOsc(lowFreqOsc),
        .restartReq(restartReq),
        .disableReq(disableReq),
        .lockReq(lockReq),
        .selWrite(selWrite),
        .selIn(selIn),
        .coreResetReq(coreResetReq),
        .enabled(enabled),
        .locked(locked),
        .selActive(selActive),
        .resetPinDrive(resetPinDrive)
    );
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("unexpected %0t seen %0h exp %0h", $time, seen, exp);
        end
    endtask
    task automatic pulse(input logic [3:0] v);
        @(negedge mclk);
        {restartReq, disableReq, lockReq, selWrite} = v;
        @(negedge mclk);
        {restartReq, disableReq, lockReq, selWrite} = 4'h0;
    endtask
    task automatic sysReset;
        reset = 1;
        repeat (3) @(negedge mclk);
        reset = 0;
    endtask
    task automatic resetValues;
        chk({enabled, locked, resetPinDrive, selActive}, 8'h27);
    endtask
    task automatic disableBack;
        pulse(4'h4);
        chk(enabled, 8'h0);
        pulse(4'h8);
        chk(enabled, 8'h1);
    endtask
    task automatic timeoutRuns;
        pulse(4'h1);
        pulse(4'h8);
        chk(selActive, 8'h0);
        repeat (8000) @(negedge mclk);
        pulse(4'h8);
        repeat (8000) @(negedge mclk);
        chk(coreResetReq, 8'h0);
        for (int i = 0; i < 1200 && coreResetReq !== 1'b1; i++) @(negedge mclk);
        chk(coreResetReq, 8'h1);
        if (coreResetReq !== 1'b1) testDone;
        sysReset;
    endtask
    task automatic lockHolds;
        pulse(4'h2);
        pulse(4'h4);
        selIn = 3'h3;
        pulse(4'h1);
        pulse(4'h8);
        chk({enabled, locked, selActive}, 8'h1F);
        sysReset;
        chk(locked, 8'h0);
    endtask
    task automatic testDone;
        if (errCount == 0 && totalChecks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        sysReset;
        resetValues;
        disableBack;
        timeoutRuns;
        resetValues;
        lockHolds;
        testDone;
    end
endmodule
bind overflow_guard_timer overflow_guard_timer_monitor mon_u (
    .mclk(mclk),
    .reset(reset),
    .restartReq(restartReq),
    .disableReq(disableReq),
    .lockReq(lockReq),
    .coreResetReq(coreResetReq),
    .enabled(enabled),
    .locked(locked),
    .selActive(selActive),
    .resetPinDrive(resetPinDrive)
);
